/* File: verilog/apc_pkg.sv */
// Package of register offsets, field positions and reset values for the
// converter control block.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package apc_pkg;
  // ----------------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------------
  localparam int ADR_W = 5;
  localparam int DAT_W = 32;
  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [4:0] OFF_PRIO = 5'h00;  // priority_conv_control
  localparam logic [4:0] OFF_MON0 = 5'h04;  // monitor0_config
  localparam logic [4:0] OFF_TRIG = 5'h08;  // trigger_and_soft_reset
  localparam logic [4:0] OFF_STAT = 5'h0C;  // interrupt status
  localparam logic [4:0] OFF_MASK = 5'h10;  // interrupt mask
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int PRIO_DONE_B  = 7;
  localparam int PRIO_BUSY_B  = 6;
  localparam int PRIO_START_B = 5;
  localparam int PRIO_SPARE_B = 4;
  localparam int MON_SPARE_B  = 7;
  localparam int MON_DIR_B    = 5;
  localparam int MON_TGT_LO   = 1;
  localparam int MON_EN_B     = 0;
  localparam int PHW_SRC_B    = 7;
  localparam int PHW_EN_B     = 6;
  localparam int NHW_SRC_B    = 5;
  localparam int NHW_EN_B     = 4;
  localparam int IRQ_DONE_B   = 0;
  localparam int IRQ_MON0_B   = 1;
  // ----------------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] KEY_FIRST  = 2'h2;
  localparam logic [1:0] KEY_SECOND = 2'h1;
  localparam logic [3:0] CHAN_RST   = 4'h0;
  localparam logic [7:0] BYTE_RST   = 8'h00;
  localparam logic [1:0] IRQ_RST    = 2'h0;
  // Soft reset key sequencer states.
  typedef enum logic {
    APC_KEY_IDLE  = 1'b0,
    APC_KEY_ARMED = 1'b1
  } apc_key_e;
endpackage : apc_pkg

/* File: verilog/apc_ctrl.sv */
// Converter control block: top-priority conversion, monitor 0 and trigger
// selection, with a classic Wishbone register slave and one interrupt.
// Assumes the converter core and timers run on clk_i; ext_trig_i is a pin.
//
// Notes on behaviour
// - Bit 7 of the priority register reads 1 once the top-priority conversion has finished, else 0.
// - Reading the priority register clears its completion flag.
// - Bit 6 of the priority register reads 1 while the top-priority conversion runs.
// - Writing 1 to bit 5 starts a top-priority conversion unless one runs, 0 does nothing, and it reads 0.
// - Bits 3-0 pick analog input 0 to 7, upper codes reserved, set before starting.
// - Monitor direction 0 flags results below compare value 0, 1 flags results above.
// - Monitor target bits 4-1 pick result 0 to 7, any code 1xxx picks the special result.
// - Monitor enable bit 0 turns the comparison and its interrupt off or on.
// - Priority trigger source picks the external pin or timer match a, gated by its enable.
// - Normal trigger source picks the external pin or timer match b, gated by its enable.
// - Writing 10 then 01 to the reset key field resets every register of the block but the bus ack, read data and trigger pin flops.
`timescale 1ns/1ns
module apc_ctrl #(
  parameter int RES_W = 12
) (
  // Clock and reset.
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Wishbone slave.
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [apc_pkg::ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [apc_pkg::DAT_W-1:0]  wb_dat_i,
  output logic      [apc_pkg::DAT_W-1:0]  wb_dat_o,
  output logic                            wb_ack_o,
  // Converter core.
  output logic                            conv_start_o,
  output logic      [3:0]                 conv_chan_o,
  input  wire logic                       conv_done_i,
  output logic                            normal_hw_start_o,
  output logic                            soft_reset_o,
  // Trigger sources.
  input  wire logic                       ext_trig_i,
  input  wire logic                       timer_match_a_i,
  input  wire logic                       timer_match_b_i,
  // Monitor 0 inputs.
  input  wire logic [8*RES_W-1:0]         result_regs_i,
  input  wire logic [RES_W-1:0]           special_result_reg_i,
  input  wire logic [RES_W-1:0]           cmp0_value_i,
  input  wire logic                       result_valid_i,
  // Interrupt.
  output logic                            irq_o
);
  import apc_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic       done_r, done_nxt;
  logic       busy_r, busy_nxt;
  logic       pspare_r, pspare_nxt;
  logic [3:0] chan_r, chan_nxt;
  logic [7:0] mon_r, mon_nxt;
  logic [3:0] trig_r, trig_nxt;
  logic [1:0] stat_r, stat_nxt;
  logic [1:0] mask_r, mask_nxt;
  logic       ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic       start_r, start_nxt;
  logic       nstart_r, nstart_nxt;
  logic       srst_r, srst_nxt;
  apc_key_e   key_r, key_nxt;
  logic       s1_r, s2_r, s3_r;
  logic       req, wr, rd, ext_rise, sw_go, hw_go, go, hit;
  logic [RES_W-1:0] res;

  // Picks the result under watch; any code with its top bit set is special.
  function automatic logic [RES_W-1:0] pick(input logic [3:0] t,
      input logic [8*RES_W-1:0] r, input logic [RES_W-1:0] sp);
    if (t[3]) begin
      return sp;
    end
    return r[32'(t[2:0])*RES_W +: RES_W];
  endfunction : pick

  // ----------------------------------------------------------------------
  // Decode and events
  // ----------------------------------------------------------------------
  // Requests are taken once; ack closes each bus cycle after one wait.
  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr  = req && wb_we_i && wb_sel_i[0];
  assign rd  = req && !wb_we_i;
  assign ext_rise = s2_r && !s3_r;
  assign sw_go = wr && (wb_adr_i == OFF_PRIO) && wb_dat_i[PRIO_START_B];
  assign hw_go = (trig_r[PHW_EN_B-4] &&
                  (trig_r[PHW_SRC_B-4] ? timer_match_a_i : ext_rise));
  assign go  = (sw_go || hw_go) && !busy_r;
  assign res = pick(mon_r[MON_TGT_LO +: 4], result_regs_i,
                    special_result_reg_i);
  assign hit = mon_r[MON_EN_B] && result_valid_i &&
               (mon_r[MON_DIR_B] ? (res > cmp0_value_i)
                                 : (res < cmp0_value_i));

  // Next values of every register of the block but the trigger pin flops.
  always_comb begin
    done_nxt   = done_r;
    busy_nxt   = busy_r;
    pspare_nxt = pspare_r;
    chan_nxt   = chan_r;
    mon_nxt    = mon_r;
    trig_nxt   = trig_r;
    stat_nxt   = stat_r;
    mask_nxt   = mask_r;
    key_nxt    = key_r;
    srst_nxt   = 1'b0;
    ack_nxt    = req;
    dat_nxt    = 32'h0000_0000;
    start_nxt  = go;
    nstart_nxt = trig_r[NHW_EN_B-4] &&
                 (trig_r[NHW_SRC_B-4] ? timer_match_b_i : ext_rise);
    // Register writes touch the low byte only; upper bits are dropped.
    if (wr) begin
      unique case (wb_adr_i)
        OFF_PRIO: begin
          pspare_nxt = wb_dat_i[PRIO_SPARE_B];
          chan_nxt   = wb_dat_i[3:0];
        end
        OFF_MON0: mon_nxt = {wb_dat_i[7], 1'b0, wb_dat_i[5:0]};
        OFF_TRIG: trig_nxt = wb_dat_i[7:4];
        OFF_STAT: stat_nxt = stat_r & ~wb_dat_i[1:0];
        OFF_MASK: mask_nxt = wb_dat_i[1:0];
        default: ;
      endcase
    end
    // Read data; unmapped offsets and upper bits read zero.
    if (rd) begin
      unique case (wb_adr_i)
        OFF_PRIO: dat_nxt = {24'h00_0000, done_r, busy_r, 1'b0,
                             pspare_r, chan_r};
        OFF_MON0: dat_nxt = {24'h00_0000, mon_r};
        OFF_TRIG: dat_nxt = {24'h00_0000, trig_r, 4'h0};
        OFF_STAT: dat_nxt = {30'h0000_0000, stat_r};
        OFF_MASK: dat_nxt = {30'h0000_0000, mask_r};
        default:  dat_nxt = 32'h0000_0000;
      endcase
      if (wb_adr_i == OFF_PRIO) begin
        done_nxt = 1'b0;
      end
    end
    // Conversion tracking; a finish in the clearing cycle still sets.
    if (go) begin
      busy_nxt = 1'b1;
      done_nxt = 1'b0;
    end else if (busy_r && conv_done_i) begin
      busy_nxt = 1'b0;
      done_nxt = 1'b1;
    end
    if (busy_r && conv_done_i) begin
      stat_nxt[IRQ_DONE_B] = 1'b1;
    end
    if (hit) begin
      stat_nxt[IRQ_MON0_B] = 1'b1;
    end
    // Reset key: 10 arms, a following 01 fires, anything else disarms.
    if (wr && (wb_adr_i == OFF_TRIG)) begin
      unique case (key_r)
        APC_KEY_IDLE: begin
          if (wb_dat_i[1:0] == KEY_FIRST) begin
            key_nxt = APC_KEY_ARMED;
          end
        end
        APC_KEY_ARMED: begin
          key_nxt  = APC_KEY_IDLE;
          srst_nxt = (wb_dat_i[1:0] == KEY_SECOND);
        end
      endcase
    end
    // Soft reset wins over everything but the bus handshake.
    if (srst_r) begin
      done_nxt   = 1'b0;
      busy_nxt   = 1'b0;
      pspare_nxt = 1'b0;
      chan_nxt   = CHAN_RST;
      mon_nxt    = BYTE_RST;
      trig_nxt   = 4'h0;
      stat_nxt   = IRQ_RST;
      mask_nxt   = IRQ_RST;
      key_nxt    = APC_KEY_IDLE;
      start_nxt  = 1'b0;
      nstart_nxt = 1'b0;
    end
  end

  // Registers; the trigger pin passes two flops before any logic.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_r   <= 1'b0;
      busy_r   <= 1'b0;
      pspare_r <= 1'b0;
      chan_r   <= CHAN_RST;
      mon_r    <= BYTE_RST;
      trig_r   <= 4'h0;
      stat_r   <= IRQ_RST;
      mask_r   <= IRQ_RST;
      key_r    <= APC_KEY_IDLE;
      srst_r   <= 1'b0;
      ack_r    <= 1'b0;
      dat_r    <= 32'h0000_0000;
      start_r  <= 1'b0;
      nstart_r <= 1'b0;
      s1_r     <= 1'b0;
      s2_r     <= 1'b0;
      s3_r     <= 1'b0;
    end else begin
      done_r   <= done_nxt;
      busy_r   <= busy_nxt;
      pspare_r <= pspare_nxt;
      chan_r   <= chan_nxt;
      mon_r    <= mon_nxt;
      trig_r   <= trig_nxt;
      stat_r   <= stat_nxt;
      mask_r   <= mask_nxt;
      key_r    <= key_nxt;
      srst_r   <= srst_nxt;
      ack_r    <= ack_nxt;
      dat_r    <= dat_nxt;
      start_r  <= start_nxt;
      nstart_r <= nstart_nxt;
      s1_r     <= ext_trig_i;
      s2_r     <= s1_r;
      s3_r     <= s2_r;
    end
  end

  // Outputs.
  assign wb_ack_o          = ack_r;
  assign wb_dat_o          = dat_r;
  assign conv_start_o      = start_r;
  assign conv_chan_o       = chan_r;
  assign normal_hw_start_o = nstart_r;
  assign soft_reset_o      = srst_r;
  assign irq_o             = |(stat_r & mask_r);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Read of the priority register clears the flag unless a finish lands.
  chk_done_read_clr: assert property (
    (rd && wb_adr_i == OFF_PRIO && !(busy_r && conv_done_i)) |=> !done_r)
    else $error("completion flag not cleared by read");
  // A finish of a running conversion sets the flag next cycle.
  chk_done_set: assert property (
    (busy_r && conv_done_i && !go && !srst_r) |=> done_r && !busy_r)
    else $error("completion flag not set on finish");
  // A software start on an idle converter shows busy and pulses start.
  chk_busy_start: assert property (
    (sw_go && !busy_r && !srst_r) |=> busy_r && conv_start_o ##1 busy_r
      || conv_done_i)
    else $error("start did not make busy");
  // Read data of the priority register hides the start bit and upper bits.
  chk_read_zero: assert property (
    (rd && wb_adr_i == OFF_PRIO) |=> wb_ack_o && wb_dat_o[5] == 1'b0
      && wb_dat_o[31:8] == 24'h00_0000)
    else $error("start bit or upper bits read nonzero");
  // Monitor hit above compare value sets its status bit.
  chk_mon_above: assert property (
    (mon_r[MON_EN_B] && mon_r[MON_DIR_B] && result_valid_i &&
     res > cmp0_value_i && !srst_r) |=> stat_r[IRQ_MON0_B])
    else $error("monitor hit above not flagged");
  // Disabled monitor never raises its status bit.
  chk_mon_off: assert property (
    (!stat_r[IRQ_MON0_B] && !mon_r[MON_EN_B]) |=> !stat_r[IRQ_MON0_B])
    else $error("disabled monitor raised status");
  // Timer match a with the priority trigger on starts a conversion.
  chk_hw_prio: assert property (
    (trig_r[2] && trig_r[3] && timer_match_a_i && !busy_r && !srst_r)
      |=> conv_start_o)
    else $error("timer trigger did not start");
  // Key sequence 10 then 01 clears the configuration two cycles later.
  chk_soft_rst: assert property (
    (wr && wb_adr_i == OFF_TRIG && wb_dat_i[1:0] == KEY_SECOND &&
     key_r == APC_KEY_ARMED) |=> soft_reset_o ##1 mon_r == BYTE_RST
      && chan_r == CHAN_RST && trig_r == 4'h0)
    else $error("soft reset did not clear registers");
  // Ack lasts one cycle.
  chk_ack_one: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  // Monitor hit below compare value sets its status bit.
  chk_mon_below: assert property (
    (mon_r[MON_EN_B] && !mon_r[MON_DIR_B] && result_valid_i &&
     res < cmp0_value_i && !srst_r) |=> stat_r[IRQ_MON0_B])
    else $error("monitor hit below not flagged");
  // A finish of a running conversion raises the done status bit.
  chk_done_irq: assert property (
    (busy_r && conv_done_i && !srst_r) |=> stat_r[IRQ_DONE_B])
    else $error("done status not set on finish");
  // A start pulse lasts one cycle, since busy blocks a second one.
  chk_start_once: assert property (
    conv_start_o |=> !conv_start_o)
    else $error("start pulse held longer than one cycle");

  cov_sw_conv: cover property (sw_go ##[1:50] (busy_r && conv_done_i));
  cov_mon_hit: cover property (hit ##1 irq_o);
  cov_soft_rst: cover property (srst_r);
  cov_hw_ext: cover property (hw_go && !trig_r[3]);
  cov_hw_norm: cover property (normal_hw_start_o);
endmodule : apc_ctrl

/* File: bench/apc_core_model.sv */
// Behavioural model of the converter core behind the control block.
// Assumes the core shares clk_i; lat_i sets the cycles from start to done.
`timescale 1ns/1ns
module apc_core_model (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Control side.
  input  wire logic       start_i,
  input  wire logic [7:0] lat_i,
  output logic            done_o
);
  logic [7:0] cnt_r;
  logic       run_r;
  // Runs one conversion per start pulse and ends it with a done pulse.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r  <= 8'h00;
      run_r  <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= run_r && (cnt_r == 8'h00);
      if (start_i && !run_r) begin
        run_r <= 1'b1;
        cnt_r <= lat_i;
      end else if (run_r && cnt_r == 8'h00) begin
        run_r <= 1'b0;
      end else if (run_r) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule : apc_core_model

/* File: bench/test_apc_ctrl.sv */
// Self-checking bench of the converter control block.
// Assumes apc_pkg, apc_ctrl and apc_core_model are compiled first.
`timescale 1ns/1ns
module test_apc_ctrl;
  import apc_pkg::*;
  // --------------------
  // Signals
  // --------------------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic        done, st, nst, srst, irq, ack;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, dat_o;
  logic [3:0]  ev = 4'h0;
  logic [3:0]  chan;
  logic [7:0]  lat = 8'h14;
  logic [11:0] spec = 12'h014;
  logic [11:0] cmp = 12'h00A;
  logic [95:0] res = {12'h800, 12'h800, 12'h800, 12'h800,
                      12'h800, 12'h005, 12'h800, 12'h800};
  int          error_cnt = 0;
  int          check_count = 0;
  int          n_st = 0;
  int          n_nst = 0;
  int          n_rst = 0;
  localparam logic [31:0] MCFG [4] = '{32'h05, 32'h25, 32'h3D, 32'h3C};
  localparam logic [31:0] MHIT [4] = '{32'h02, 32'h00, 32'h02, 32'h00};
  localparam logic [15:0] TTAB [6] = '{16'hC012, 16'h8010, 16'h4002,
                                       16'h3021, 16'h1001, 16'h2020};
  // Clock and pulse counters on the converter side.
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    n_st  += (st === 1'b1);
    n_nst += (nst === 1'b1);
    n_rst += (srst === 1'b1);
  end
  apc_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .conv_start_o(st),
    .conv_chan_o(chan), .conv_done_i(done), .normal_hw_start_o(nst),
    .soft_reset_o(srst), .ext_trig_i(ev[0]), .timer_match_a_i(ev[1]),
    .timer_match_b_i(ev[2]), .result_regs_i(res),
    .special_result_reg_i(spec), .cmp0_value_i(cmp),
    .result_valid_i(ev[3]), .irq_o(irq));
  apc_core_model core_u (.clk_i(clk_i), .rst_i(rst_i), .start_i(st),
    .lat_i(lat), .done_o(done));
  // --------------------
  // Shared tasks
  // --------------------
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One classic Wishbone cycle; holds the request until ack is sampled.
  task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) error_cnt++;
    rdat = dat_o;
    cyc <= 1'b0;
  endtask : bus
  task automatic rd(logic [4:0] a, logic [31:0] e, string s);
    bus(1'b0, a, 32'h0000_0000);
    check(s, rdat, e);
  endtask : rd
  task automatic pulse(int k);
    @(posedge clk_i);
    ev <= 4'h1 << k;
    @(posedge clk_i);
    ev <= 4'h0;
  endtask : pulse
  // --------------------
  // Scenarios
  // --------------------
  task automatic t_reset();
    rd(OFF_PRIO, 32'h0000_0000, "prio");
    rd(OFF_MON0, 32'h0000_0000, "mon0");
    rd(OFF_TRIG, 32'h0000_0000, "trig");
    rd(OFF_MASK, 32'h0000_0000, "mask");
    rd(5'h14, 32'h0000_0000, "unmapped");
  endtask : t_reset
  // Start, start again while busy, then finish, read-clear and interrupt.
  task automatic t_prio();
    bus(1'b1, OFF_PRIO, 32'hFFFF_FF13);
    rd(OFF_PRIO, 32'h0000_0013, "prio wide");
    bus(1'b1, OFF_PRIO, 32'h0000_0003);
    bus(1'b1, OFF_PRIO, 32'h0000_0023);
    bus(1'b1, OFF_PRIO, 32'h0000_0023);
    check("chan", {28'h0, chan}, 32'h0000_0003);
    check("starts", 32'(n_st), 32'h0000_0001);
    rd(OFF_PRIO, 32'h0000_0043, "busy");
    repeat (40) @(posedge clk_i);
    rd(OFF_PRIO, 32'h0000_0083, "done");
    rd(OFF_PRIO, 32'h0000_0003, "done clr");
    check("irq off", {31'h0, irq}, 32'h0000_0000);
    bus(1'b1, OFF_MASK, 32'h0000_0001);
    check("irq on", {31'h0, irq}, 32'h0000_0001);
    bus(1'b1, OFF_STAT, 32'h0000_0001);
    check("irq clr", {31'h0, irq}, 32'h0000_0000);
    bus(1'b1, OFF_PRIO, 32'h0000_0003);
    check("start0", 32'(n_st), 32'h0000_0001);
  endtask : t_prio
  // Direction, target and enable of monitor 0.
  task automatic t_mon();
    bus(1'b1, OFF_MON0, 32'hFFFF_FFFF);
    rd(OFF_MON0, 32'h0000_00BF, "mon0 wide");
    bus(1'b1, OFF_MASK, 32'h0000_0002);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, OFF_MON0, MCFG[i]);
      pulse(3);
      repeat (2) @(posedge clk_i);
      check("irq mon", {31'h0, irq}, {31'h0, MHIT[i][1]});
      rd(OFF_STAT, MHIT[i], "mon hit");
      bus(1'b1, OFF_STAT, 32'h0000_0003);
    end
  endtask : t_mon
  // Hardware trigger sources and enables; the pin is never shared.
  task automatic t_trig();
    int s0;
    int n0;
    lat <= 8'h01;
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, OFF_TRIG, {24'h0, TTAB[i][15:8]});
      rd(OFF_TRIG, {24'h0, TTAB[i][15:8]}, "trig rb");
      s0 = n_st;
      n0 = n_nst;
      pulse(int'(TTAB[i][5:4]));
      repeat (8) @(posedge clk_i);
      check("hw prio", 32'(n_st - s0), {31'h0, TTAB[i][1]});
      check("hw norm", 32'(n_nst - n0), {31'h0, TTAB[i][0]});
    end
  endtask : t_trig
  // Broken key sequence, then a proper one that clears everything.
  task automatic t_srst();
    bus(1'b1, OFF_MASK, 32'h0000_0003);
    bus(1'b1, OFF_MON0, 32'h0000_003D);
    bus(1'b1, OFF_TRIG, 32'h0000_0002);
    bus(1'b1, OFF_TRIG, 32'h0000_0000);
    bus(1'b1, OFF_TRIG, 32'h0000_0001);
    check("no reset", 32'(n_rst), 32'h0000_0000);
    bus(1'b1, OFF_PRIO, 32'h0000_0005);
    bus(1'b1, OFF_TRIG, 32'h0000_00C2);
    check("irq pre", {31'h0, irq}, 32'h0000_0001);
    bus(1'b1, OFF_TRIG, 32'h0000_00C1);
    repeat (3) @(posedge clk_i);
    check("reset", 32'(n_rst), 32'h0000_0001);
    rd(OFF_PRIO, 32'h0000_0000, "prio clr");
    rd(OFF_MON0, 32'h0000_0000, "mon0 clr");
    rd(OFF_TRIG, 32'h0000_0000, "trig clr");
    rd(OFF_MASK, 32'h0000_0000, "mask clr");
    rd(OFF_STAT, 32'h0000_0000, "stat clr");
    check("irq post", {31'h0, irq}, 32'h0000_0000);
  endtask : t_srst
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  // Main sequence after a two-cycle reset.
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_prio();
    t_mon();
    t_trig();
    t_srst();
    print_verdict();
  end
  // Watchdog well beyond the expected few thousand nanoseconds.
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
endmodule : test_apc_ctrl
